// ---- rtl/apm_pkg.sv ----
// constants and types for the converter power-mode and framing control
// Summary of operation
// - power bits 1,1 select normal, always powered
// - chip select falling starts conversion, holds sample; the code holds from the first falling sclk edge
// - write bit one loads first 12 bits
// - write bit zero keeps power bits unchanged
// - sixteen clocks per conversion; track at 14th
// - power bits 1,0 select persistent full shutdown
// - control register kept through full shutdown
// - wake write powers up at chip select rise
// - wake transfer full length, data-out stays undriven
// - power bits 0,1 auto shutdown after each conversion
// - auto shutdown wakes and tracks on select fall
// - full shutdown after power-on: one dummy cycle
// - auto shutdown after power-on: two dummy cycles
// - range bit selects span of ref or twice ref
// - early chip select rise aborts, no register update
// - top incoming bit is the write bit
// - output: two zeros, channel id, 12-bit result
package apm_pkg;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CTRL_BITS = 12;
  localparam logic [4:0] TRACK_EDGE = 5'h0E;
  localparam logic [4:0] LAST_EDGE = 5'h10;
  // control field positions within the 12 written bits
  localparam int unsigned WRITE_POS = 11;
  localparam int unsigned PM_HI_POS = 5;
  localparam int unsigned PM_LO_POS = 4;
  localparam int unsigned CH_HI_POS = 7;
  localparam int unsigned CH_LO_POS = 6;
  localparam int unsigned RANGE_POS = 1;
  localparam int unsigned CODING_POS = 0;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 12'h000;
  localparam logic [1:0] MODE_RESET = 2'h1;

  typedef enum logic [1:0] {
    APM_FULL_SHUTDOWN = 2'h2,
    APM_AUTO_SHUTDOWN = 2'h1,
    APM_NORMAL = 2'h3
  } apm_mode_e;

  typedef enum logic [2:0] {
    APM_IDLE = 3'h1,
    APM_XFER = 3'h2,
    APM_DONE = 3'h4
  } apm_state_e;

  // end-of-frame report carried to the system clock
  typedef struct packed {
    logic complete;
    logic write;
    logic [CTRL_BITS-1:0] ctrl;
  } apm_frame_s;
endpackage

// ---- rtl/apm_sync.sv ----
// two-flop level synchroniser bank
`timescale 1ns/10ps
`default_nettype none
module apm_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/apm_core.sv ----
// converter power-mode and serial framing control
`timescale 1ns/10ps
`default_nettype none
module apm_core
  import apm_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // power-on mode pick, arbitrary
  input wire logic [1:0] start_mode,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // conversion result input
  input wire logic [11:0] sample_data,
  // status
  output logic [1:0] mode,
  output logic powered,
  output logic tracking,
  output logic range_double,
  output logic coding_twos,
  output logic [1:0] channel_id,
  output logic frame_abort
);
  // ----------------------------------------------------------------
  // link domain: shifting on falling sclk edges
  // ----------------------------------------------------------------
  // link count, hold, toggle and output flops start known: the link has no reset of its own
  logic [4:0] edge_cnt = 5'h00;
  logic [CTRL_BITS-1:0] shift_in;
  logic [WORD_BITS-1:0] out_word;
  logic [3:0] out_idx;
  logic hold_link = 1'b0;
  logic [1:0] ch_link;
  logic wake_blank;
  logic blank_sys;
  logic oe_stop;
  logic dout_q = 1'b0;
  logic oe_q = 1'b0;

  // frame start captured by a select-fall toggle
  logic start_tgl = 1'b0;
  always_ff @(negedge cs_n) begin
    start_tgl <= ~start_tgl;
  end

  // edge counter, frame kept alive by cs_n low
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_cnt <= 5'h00;
    end else if (edge_cnt != 5'h1F) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end

  always_ff @(negedge sclk) begin
    if (!cs_n && edge_cnt < 5'(CTRL_BITS)) begin
      shift_in <= {shift_in[CTRL_BITS-2:0], din};
    end
  end

  // output word: two zeros, channel, result
  assign out_word = {2'h0, ch_link, sample_data};
  // bit shown after a falling edge, counted before that edge
  assign out_idx = 4'hE - edge_cnt[3:0];
  // enable window ends on 16th edge or select rise
  assign oe_stop = cs_n | (edge_cnt >= LAST_EDGE);

  // hold from first falling sclk edge to 14th falling edge
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      hold_link <= 1'b0;
    end else begin
      hold_link <= (edge_cnt < TRACK_EDGE - 5'h01);
    end
  end

  // end-of-frame report, latched at select rise
  apm_frame_s frame_link;
  logic frame_tgl = 1'b0;
  always_ff @(posedge cs_n) begin
    frame_link.complete <= (edge_cnt >= LAST_EDGE);
    frame_link.write <= shift_in[WRITE_POS];
    frame_link.ctrl <= shift_in;
    frame_tgl <= ~frame_tgl;
  end

  // ----------------------------------------------------------------
  // crossings into the system clock
  // ----------------------------------------------------------------
  logic [2:0] raw_lvls;
  logic [2:0] sync_lvls;
  assign raw_lvls = {frame_tgl, start_tgl, hold_link};

  apm_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(raw_lvls),
    .q(sync_lvls)
  );

  logic frame_seen;
  logic start_prev;
  logic frame_evt;
  logic frame_evt_q;
  logic start_evt;
  assign frame_evt = sync_lvls[2] ^ frame_seen;
  assign start_evt = sync_lvls[1] ^ start_prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_seen <= 1'b0;
      start_prev <= 1'b0;
      frame_evt_q <= 1'b0;
    end else begin
      frame_seen <= sync_lvls[2];
      start_prev <= sync_lvls[1];
      frame_evt_q <= frame_evt;
    end
  end

  // ----------------------------------------------------------------
  // control register and power mode
  // ----------------------------------------------------------------
  logic [CTRL_BITS-1:0] ctrl;
  logic init_done;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      mode <= MODE_RESET;
      init_done <= 1'b0;
    end else if (!init_done) begin
      mode <= start_mode;
      init_done <= 1'b1;
    end else if (frame_evt && frame_link.complete
        && frame_link.write) begin
      ctrl <= frame_link.ctrl;
      mode <= {frame_link.ctrl[PM_HI_POS],
               frame_link.ctrl[PM_LO_POS]};
    end
  end

  // powered state per mode
  always_ff @(posedge clk) begin
    if (rst) begin
      powered <= 1'b0;
    end else begin
      case (mode)
        APM_NORMAL: powered <= 1'b1;
        APM_FULL_SHUTDOWN: powered <= 1'b0;
        APM_AUTO_SHUTDOWN: begin
          if (start_evt) begin
            powered <= 1'b1;
          end else if (frame_evt_q) begin
            powered <= 1'b0;
          end
        end
        default: powered <= powered;
      endcase
    end
  end

  // status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      tracking <= 1'b0;
      range_double <= 1'b0;
      coding_twos <= 1'b0;
      channel_id <= 2'h0;
      frame_abort <= 1'b0;
    end else begin
      tracking <= powered & ~sync_lvls[0];
      range_double <= ~ctrl[RANGE_POS];
      coding_twos <= ~ctrl[CODING_POS];
      channel_id <= {ctrl[CH_HI_POS], ctrl[CH_LO_POS]};
      frame_abort <= frame_evt & ~frame_link.complete;
    end
  end

  // shutdown flag for the link; static while cs_n is low, since
  // mode only moves a few clocks after a select rise
  always_ff @(posedge clk) begin
    if (rst) begin
      blank_sys <= 1'b0;
    end else begin
      blank_sys <= (mode == APM_FULL_SHUTDOWN);
    end
  end
  assign wake_blank = blank_sys;

  // channel fed back to the link, stable between frames
  always_ff @(posedge sclk) begin
    ch_link <= channel_id;
  end

  // data-out from flop; leading zero shown from select fall
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      dout_q <= 1'b0;
    end else begin
      dout_q <= out_word[out_idx];
    end
  end

  // enable on at select fall outside full shutdown, off on 16th edge or select rise
  always_ff @(negedge cs_n or posedge oe_stop) begin
    if (cs_n || edge_cnt >= LAST_EDGE) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~wake_blank;
    end
  end
  assign dout = dout_q;
  assign dout_oe = oe_q;
endmodule
`default_nettype wire

// ---- tb/apm_checker.sv ----
// assertions on the power-mode control ports
`timescale 1ns/10ps
`default_nettype none
module apm_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire logic cs_n,
  input wire logic dout_oe,
  input wire logic [1:0] mode,
  input wire logic powered,
  input wire logic tracking,
  input wire logic frame_abort
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  normal_power_a: assert property ((mode == 2'h3) [*8] |-> powered)
    else $error("normal mode not powered");
  full_power_a: assert property ((mode == 2'h2) [*8] |-> !powered)
    else $error("full shutdown powered");
  auto_power_a: assert property ((mode == 2'h1 && cs_n) [*8] |-> !powered)
    else $error("auto shutdown left powered");
  hold_start_a: assert property ($fell(cs_n) && mode != 2'h1 |-> ##[2:8] !tracking)
    else $error("no hold after select fall");
  auto_wake_a: assert property ($fell(cs_n) && mode == 2'h1 |-> ##[2:8] powered)
    else $error("no wake after select fall");
  mode_frame_a: assert property ((!cs_n) [*6] |-> $stable(mode))
    else $error("mode changed within frame");
  oe_idle_a: assert property (cs_n [*4] |-> !dout_oe)
    else $error("data out driven while idle");
  oe_full_a: assert property (mode == 2'h2 |-> !dout_oe)
    else $error("data out driven in shutdown");
  abort_keep_a: assert property (frame_abort |=> $stable(mode) [*6])
    else $error("mode changed after abort");
endmodule
bind apm_core apm_checker chk_u (.clk(clk), .rst(rst), .cs_n(cs_n),
  .dout_oe(dout_oe), .mode(mode), .powered(powered), .tracking(tracking),
  .frame_abort(frame_abort));
`default_nettype wire

// ---- tb/apm_host.sv ----
// serial host model that frames transfers into the converter
`timescale 1ns/10ps
`default_nettype none
module apm_host (
  // link out
  output logic sclk,
  output logic cs_n,
  output logic din,
  // link in
  input wire logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // n falling edges, msb first, then a quiet gap
  task automatic frame(input logic [15:0] w, input int n,
                       output logic [15:0] r);
    r = 16'h0000;
    cs_n = 1'b0;
    din = w[15];
    for (int i = 0; i < n; i++) begin
      #14 r = {r[14:0], dout};
      #1 sclk = 1'b0;
      #15 sclk = 1'b1;
      din = (i < 15) ? w[14-i] : ~din;
    end
    #15 cs_n = 1'b1;
    din = ~din;
    #4600;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_adc_power_mode_control.sv ----
// self-checking bench for the power-mode control
`timescale 1ns/10ps
`default_nettype none
module tb_adc_power_mode_control;
  import apm_pkg::*;
  logic clk, rst, sclk, cs_n, din, dout, dout_oe, powered, tracking;
  logic range_double, coding_twos, frame_abort;
  logic [1:0] start_mode, mode, channel_id;
  logic [11:0] sample_data;
  logic [15:0] rd;
  int miscompares = 0;
  int checks_done = 0;
  int aborts = 0;
  int a0;
  apm_core dut_u (.clk(clk), .rst(rst), .start_mode(start_mode),
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .sample_data(sample_data), .mode(mode), .powered(powered),
    .tracking(tracking), .range_double(range_double),
    .coding_twos(coding_twos), .channel_id(channel_id),
    .frame_abort(frame_abort));
  apm_host host_u (.sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout_oe ? dout : ~dout));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) if (frame_abort === 1'b1) aborts++;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] pm, ch, input logic rng, cod);
    host_u.frame({4'h8, ch, pm, 2'h0, rng, cod, 4'h0}, 16, rd);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // dummy frame with data-in high from full shutdown
  task automatic t_power_on;
    chk(mode, 2'h2);
    chk(powered, 1'b0);
    host_u.frame(16'hFFFF, 16, rd);
    chk(mode, 2'h3);
    chk(powered, 1'b1);
    chk({channel_id, range_double, coding_twos}, 4'hC);
  endtask
  // read frame, write bit low
  task automatic t_read;
    @(negedge clk) sample_data = 12'hA5C;
    host_u.frame(16'h0200, 16, rd);
    chk(rd, 16'h3A5C);
    chk(mode, 2'h3);
    chk(tracking, 1'b1);
  endtask
  // write cut short after ten edges
  task automatic t_abort;
    a0 = aborts;
    host_u.frame(16'h8200, 10, rd);
    chk(aborts - a0, 1);
    chk({mode, channel_id}, 4'hF);
  endtask
  // full shutdown, kept register, wake write
  task automatic t_full;
    wr(2'h2, 2'h1, 1'b0, 1'b0);
    chk({mode, powered}, 3'h4);
    chk({channel_id, range_double, coding_twos}, 4'h7);
    host_u.frame(16'h0300, 16, rd);
    chk({mode, channel_id}, 4'h9);
    wr(2'h3, 2'h1, 1'b0, 1'b0);
    chk({mode, powered}, 3'h7);
  endtask
  // auto shutdown and dummy wake
  task automatic t_auto;
    wr(2'h1, 2'h2, 1'b1, 1'b0);
    chk({mode, powered, channel_id}, 5'h0A);
    host_u.frame(16'h0000, 16, rd);
    chk({mode, powered}, 3'h2);
  endtask
  initial begin
    #200000;
    miscompares++;
    finish_test;
  end
  initial begin
    rst = 1'b1;
    start_mode = 2'h2;
    sample_data = 12'h000;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_power_on;
    t_read;
    t_abort;
    t_full;
    t_auto;
    finish_test;
  end
endmodule
`default_nettype wire
